// [rtl/halt_home_pkg.sv]
// Package: register map, field layout, reset values and types for halt/home-offset block
package halt_home_pkg;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS    = 8'h00;  // Commands (write pulses)
  localparam logic [7:0] CFG_OFS     = 8'h04;  // Halt action, polarity, port assign
  localparam logic [7:0] OFFSET_OFS  = 8'h08;  // Signed home offset, 24 bits
  localparam logic [7:0] SPEED_OFS   = 8'h0c;  // Operating speed
  localparam logic [7:0] STATUS_OFS  = 8'h10;  // Block state

  // Control bit positions
  localparam int CTRL_HALT_BIT  = 0;  // Halt command
  localparam int CTRL_RUN_BIT   = 1;  // Program run command
  localparam int CTRL_ACLR_BIT  = 2;  // Alarm clear command
  localparam int CTRL_HSP_BIT   = 3;  // Home seek positive
  localparam int CTRL_HSN_BIT   = 4;  // Home seek negative

  // Config field positions
  localparam int CFG_ACT_BIT    = 0;  // Halt action select
  localparam int CFG_POL_BIT    = 1;  // Halt input polarity
  localparam int CFG_PORT_LSB   = 4;  // Halt input port assign, 3 bits

  // Widths
  localparam int OFFSET_W       = 24;  // Offset width
  localparam int SPEED_W        = 24;  // Speed width
  localparam int PORT_W         = 3;   // Port index width

  // Reset values
  localparam logic       ACT_RST    = 1'b1;   // Decelerate to stop
  localparam logic       POL_RST    = 1'b0;   // Active when ON
  localparam logic [2:0] PORT_RST   = 3'h0;   // Port X0
  localparam logic [23:0] OFFSET_RST = 24'h000000;  // Zero steps
  localparam logic [23:0] SPEED_RST  = 24'h000000;  // No speed set

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;  // Normal
  localparam logic [1:0] RESP_SLVERR = 2'b10;  // Unmapped address

  // Stop kinds
  typedef enum logic [1:0] {
    STOP_NONE  = 2'b00,
    STOP_IMMED = 2'b01,
    STOP_DECEL = 2'b11
  } stop_kind_t;

  // Motion state, Gray along idle -> seek -> offset; offset -> idle flips both bits
  typedef enum logic [1:0] {
    MS_IDLE   = 2'b00,
    MS_SEEK   = 2'b01,
    MS_OFFSET = 2'b11,
    MS_HALT   = 2'b10
  } motion_st_t;

  // Motion request to the motor core
  typedef struct packed {
    logic              seek_go;   // Home seek active
    logic              seek_dir;  // 1 = positive
    logic              ofs_go;    // Offset move active
    logic [23:0]       ofs_steps; // Signed offset
    logic [23:0]       speed;     // Speed in use
  } motion_req_t;

endpackage

// [rtl/halt_input_cond.sv]
// Halt input selection and polarity conditioning
`timescale 1ns/100ps
`default_nettype none
module halt_input_cond #(
  parameter int PORTS = 8  // General input port count
) (
  input  wire logic [PORTS-1:0] i_ports,     // General input levels
  input  wire logic [2:0]       i_port_sel,  // Assigned port
  input  wire logic             i_polarity,  // 1 = inverted
  output logic                  o_active     // Halt requested
);
  // Polarity applied before use: inverted means OFF is active
  always_comb begin
    o_active = i_ports[i_port_sel] ^ i_polarity;
  end
endmodule
`default_nettype wire

// [rtl/motor_halt_and_home_offset.sv]
// Motor halt control and home-seek offset with AXI4-Lite registers
`timescale 1ns/100ps
`default_nettype none
// Contract
// - Halt command stops using selected action
// - Polarity 0 ON-active, 1 OFF-active, default 0
// - Polarity volatile, reverts on reinit events
// - Program start restores polarity default
// - Alarm clear restores polarity default
// - Signed 24-bit offset, default zero, applied
// - Offset reset at power-on and alarm clear
// - New speed used during offset move
// - Action 0 immediate, 1 decelerate, default 1
// - Halt input stops motor, program continues
module motor_halt_and_home_offset
  import halt_home_pkg::*;
#(
  parameter int PORTS = 8  // General input port count
) (
  input  wire logic                      I_MCLK,         // 50 MHz clock
  input  wire logic                      I_RESET_N,      // Sync reset, low
  input  wire logic [PORTS-1:0]          I_GEN_IN,       // General input ports
  input  wire logic                      I_START,        // Program start input
  input  wire logic                      I_ALARM_CLEAR,  // Alarm clear input
  input  wire logic                      I_SEEK_DONE,    // Home sensor found
  input  wire logic                      I_OFS_DONE,     // Offset move finished
  input  wire logic                      I_STOPPED,      // Motor at rest
  input  wire logic [7:0]                I_AWADDR,       // AXI write addr
  input  wire logic                      I_AWVALID,      // AXI
  output logic                           O_AWREADY,      // AXI
  input  wire logic [31:0]               I_WDATA,        // AXI
  input  wire logic [3:0]                I_WSTRB,        // AXI
  input  wire logic                      I_WVALID,       // AXI
  output logic                           O_WREADY,       // AXI
  output logic [1:0]                     O_BRESP,        // AXI
  output logic                           O_BVALID,       // AXI
  input  wire logic                      I_BREADY,       // AXI
  input  wire logic [7:0]                I_ARADDR,       // AXI read addr
  input  wire logic                      I_ARVALID,      // AXI
  output logic                           O_ARREADY,      // AXI
  output logic [31:0]                    O_RDATA,        // AXI
  output logic [1:0]                     O_RRESP,        // AXI
  output logic                           O_RVALID,       // AXI
  input  wire logic                      I_RREADY,       // AXI
  output halt_home_pkg::stop_kind_t      O_STOP,         // Stop request
  output halt_home_pkg::motion_req_t     O_MOTION,       // Motion request
  output logic                           O_PROG_RUN      // Program running
);
  import halt_home_pkg::*;

  // Register state
  logic              act_q, act_d;          // Halt action select
  logic              pol_q, pol_d;          // Halt input polarity
  logic [2:0]        port_q, port_d;        // Halt input port assign
  logic [23:0]       ofs_q, ofs_d;          // Home offset
  logic [23:0]       spd_q, spd_d;          // Operating speed
  logic              prun_q, prun_d;        // Program running
  // Bus state
  logic              aw_q, aw_d;            // Address held
  logic              w_q, w_d;              // Data held
  logic [7:0]        awa_q, awa_d;          // Held write address
  logic [31:0]       wd_q, wd_d;            // Held write data
  logic [3:0]        ws_q, ws_d;            // Held strobes
  logic              bv_q, bv_d;            // Write response valid
  logic [1:0]        br_q, br_d;            // Write response code
  logic              rv_q, rv_d;            // Read valid
  logic [31:0]       rd_q, rd_d;            // Read data
  logic [1:0]        rr_q, rr_d;            // Read response code
  // Motion state
  motion_st_t        ms_q, ms_d;            // Motion phase
  logic              sdir_q, sdir_d;        // Seek direction
  stop_kind_t        stop_q, stop_d;        // Stop output
  // Decoded strobes
  logic              wr_fire;               // Write commits this cycle
  logic [31:0]       wdata;                 // Write data in use
  logic [7:0]        waddr;                 // Write address in use
  logic              c_halt, c_run, c_aclr; // Command pulses
  logic              c_hsp, c_hsn;          // Seek commands
  logic              halt_in;               // Conditioned halt input
  logic              prog_start;            // Run command or start input
  logic              alarm_clr;             // Alarm clear by either path

  // Halt input conditioning
  halt_input_cond #(.PORTS(PORTS)) halt_input_cond_i (
    .i_ports    (I_GEN_IN),
    .i_port_sel (port_q),
    .i_polarity (pol_q),
    .o_active   (halt_in)
  );

  // Bus channel handshakes
  assign O_AWREADY = !aw_q && !bv_q;
  assign O_WREADY  = !w_q && !bv_q;
  assign O_ARREADY = !rv_q;
  assign O_BVALID  = bv_q;
  assign O_BRESP   = br_q;
  assign O_RVALID  = rv_q;
  assign O_RDATA   = rd_q;
  assign O_RRESP   = rr_q;

  // Write capture and commit decode
  always_comb begin
    aw_d  = aw_q;
    w_d   = w_q;
    awa_d = awa_q;
    wd_d  = wd_q;
    ws_d  = ws_q;
    if (I_AWVALID && O_AWREADY) begin
      aw_d  = 1'b1;
      awa_d = I_AWADDR;
    end
    if (I_WVALID && O_WREADY) begin
      w_d  = 1'b1;
      wd_d = I_WDATA;
      ws_d = I_WSTRB;
    end
    wr_fire = aw_d && w_d && !bv_q;
    waddr   = aw_q ? awa_q : I_AWADDR;
    wdata   = w_q ? wd_q : I_WDATA;
    if (wr_fire) begin
      aw_d = 1'b0;
      w_d  = 1'b0;
    end
    if (!(w_q ? ws_q[0] : I_WSTRB[0])) begin
      wdata[7:0] = 8'h00;
    end
  end

  // Command pulses from control register writes
  always_comb begin
    c_halt = wr_fire && waddr == CTRL_OFS && wdata[CTRL_HALT_BIT];
    c_run  = wr_fire && waddr == CTRL_OFS && wdata[CTRL_RUN_BIT];
    c_aclr = wr_fire && waddr == CTRL_OFS && wdata[CTRL_ACLR_BIT];
    c_hsp  = wr_fire && waddr == CTRL_OFS && wdata[CTRL_HSP_BIT];
    c_hsn  = wr_fire && waddr == CTRL_OFS && wdata[CTRL_HSN_BIT];
    prog_start = c_run || I_START;
    alarm_clr  = c_aclr || I_ALARM_CLEAR;
  end

  // Register and bus next values
  always_comb begin
    act_d  = act_q;
    pol_d  = pol_q;
    port_d = port_q;
    ofs_d  = ofs_q;
    spd_d  = spd_q;
    prun_d = prog_start ? 1'b1 : prun_q;
    bv_d   = bv_q;
    br_d   = br_q;
    if (bv_q && I_BREADY) begin
      bv_d = 1'b0;
    end
    if (wr_fire) begin
      bv_d = 1'b1;
      br_d = RESP_OKAY;
      case (waddr)
        CFG_OFS: begin
          act_d  = wdata[CFG_ACT_BIT];
          pol_d  = wdata[CFG_POL_BIT];
          port_d = wdata[CFG_PORT_LSB +: PORT_W];
        end
        OFFSET_OFS: ofs_d = wdata[OFFSET_W-1:0];
        SPEED_OFS:  spd_d = wdata[SPEED_W-1:0];
        CTRL_OFS:   ;
        STATUS_OFS: ;
        default:    br_d = RESP_SLVERR;
      endcase
    end
    // Reinit events return volatile settings to defaults
    if (prog_start || alarm_clr) begin
      pol_d = POL_RST;
    end
    if (alarm_clr) begin
      ofs_d = OFFSET_RST;
    end
  end

  // Read channel
  always_comb begin
    rv_d = rv_q;
    rd_d = rd_q;
    rr_d = rr_q;
    if (rv_q && I_RREADY) begin
      rv_d = 1'b0;
    end
    if (I_ARVALID && O_ARREADY) begin
      rv_d = 1'b1;
      rr_d = RESP_OKAY;
      case (I_ARADDR)
        CTRL_OFS:   rd_d = 32'h00000000;
        CFG_OFS:    rd_d = {25'h0, port_q, 2'h0, pol_q, act_q};
        OFFSET_OFS: rd_d = {{8{ofs_q[23]}}, ofs_q};
        SPEED_OFS:  rd_d = {8'h00, spd_q};
        STATUS_OFS: rd_d = {26'h0, halt_in, prun_q, sdir_q, ms_q, stop_q[0]};
        default: begin
          rd_d = 32'h00000000;
          rr_d = RESP_SLVERR;
        end
      endcase
    end
  end

  // Motion sequencing and stop selection
  always_comb begin
    ms_d   = ms_q;
    sdir_d = sdir_q;
    stop_d = STOP_NONE;
    case (ms_q)
      MS_IDLE: begin
        if (c_hsp || c_hsn) begin
          ms_d   = MS_SEEK;
          sdir_d = c_hsp;
        end
      end
      MS_SEEK:   if (I_SEEK_DONE) ms_d = MS_OFFSET;
      MS_OFFSET: if (I_OFS_DONE) ms_d = MS_IDLE;
      MS_HALT:   if (I_STOPPED) ms_d = MS_IDLE;
      default:   ms_d = MS_IDLE;
    endcase
    // Halt by command or input overrides motion
    if (c_halt || halt_in) begin
      stop_d = act_q ? STOP_DECEL : STOP_IMMED;
      ms_d   = (ms_q == MS_IDLE) ? MS_IDLE : MS_HALT;
    end
  end

  // Motion request; speed always follows the live register
  always_comb begin
    O_MOTION.seek_go   = ms_q == MS_SEEK;
    O_MOTION.seek_dir  = sdir_q;
    O_MOTION.ofs_go    = ms_q == MS_OFFSET;
    O_MOTION.ofs_steps = ofs_q;
    O_MOTION.speed     = spd_q;
  end
  assign O_STOP     = stop_q;
  assign O_PROG_RUN = prun_q;

  // State registers
  always_ff @(posedge I_MCLK) begin
    if (!I_RESET_N) begin
      act_q  <= ACT_RST;
      pol_q  <= POL_RST;
      port_q <= PORT_RST;
      ofs_q  <= OFFSET_RST;
      spd_q  <= SPEED_RST;
      prun_q <= 1'b0;
      aw_q   <= 1'b0;
      w_q    <= 1'b0;
      awa_q  <= 8'h00;
      wd_q   <= 32'h00000000;
      ws_q   <= 4'h0;
      bv_q   <= 1'b0;
      br_q   <= RESP_OKAY;
      rv_q   <= 1'b0;
      rd_q   <= 32'h00000000;
      rr_q   <= RESP_OKAY;
      ms_q   <= MS_IDLE;
      sdir_q <= 1'b0;
      stop_q <= STOP_NONE;
    end else begin
      act_q  <= act_d;
      pol_q  <= pol_d;
      port_q <= port_d;
      ofs_q  <= ofs_d;
      spd_q  <= spd_d;
      prun_q <= prun_d;
      aw_q   <= aw_d;
      w_q    <= w_d;
      awa_q  <= awa_d;
      wd_q   <= wd_d;
      ws_q   <= ws_d;
      bv_q   <= bv_d;
      br_q   <= br_d;
      rv_q   <= rv_d;
      rd_q   <= rd_d;
      rr_q   <= rr_d;
      ms_q   <= ms_d;
      sdir_q <= sdir_d;
      stop_q <= stop_d;
    end
  end

  // Halt command yields stop of the selected kind next cycle
  property p_halt_cmd;
    @(posedge I_MCLK) disable iff (!I_RESET_N)
    c_halt |=> (O_STOP == ($past(act_q) ? STOP_DECEL : STOP_IMMED));
  endproperty
  a_halt_cmd: assert property (p_halt_cmd) else $error("halt cmd stop wrong");

  property p_pol_input;
    @(posedge I_MCLK) disable iff (!I_RESET_N)
    (I_GEN_IN[port_q] != pol_q) |=> (O_STOP != STOP_NONE);
  endproperty
  a_pol_input: assert property (p_pol_input) else $error("halt input ignored");

  property p_pol_start;
    @(posedge I_MCLK) disable iff (!I_RESET_N)
    prog_start |=> (pol_q == POL_RST);
  endproperty
  a_pol_start: assert property (p_pol_start) else $error("polarity kept on start");

  property p_pol_aclr;
    @(posedge I_MCLK) disable iff (!I_RESET_N)
    alarm_clr |=> (pol_q == POL_RST) && (ofs_q == OFFSET_RST);
  endproperty
  a_pol_aclr: assert property (p_pol_aclr) else $error("alarm clear reinit");

  property p_ofs_reset;
    @(posedge I_MCLK) $rose(I_RESET_N) |-> (ofs_q == OFFSET_RST) && act_q && !pol_q;
  endproperty
  a_ofs_reset: assert property (p_ofs_reset) else $error("reset defaults");

  property p_ofs_write;
    @(posedge I_MCLK) disable iff (!I_RESET_N)
    (wr_fire && waddr == OFFSET_OFS && !alarm_clr) |=> ofs_q == $past(wdata[23:0]);
  endproperty
  a_ofs_write: assert property (p_ofs_write) else $error("offset not stored");

  property p_speed_live;
    @(posedge I_MCLK) disable iff (!I_RESET_N)
    (ms_q == MS_OFFSET && wr_fire && waddr == SPEED_OFS && !alarm_clr)
      |=> O_MOTION.speed == $past(wdata[23:0]);
  endproperty
  a_speed_live: assert property (p_speed_live) else $error("stale speed");

  property p_prog_cont;
    @(posedge I_MCLK) disable iff (!I_RESET_N)
    (prun_q && halt_in) |=> prun_q;
  endproperty
  a_prog_cont: assert property (p_prog_cont) else $error("program stopped");

endmodule
`default_nettype wire

// [testbench/gen_in_model.sv]
// External controller model that drives the general input ports
`timescale 1ns/100ps
`default_nettype none
module gen_in_model #(
  parameter int PORTS = 8  // Port count
) (
  input  wire logic             i_clk,    // Bench clock
  input  wire logic [PORTS-1:0] i_level,  // Requested switch levels
  output logic      [PORTS-1:0] o_ports   // Levels seen on the ports
);
  // Switch contacts change just after a clock edge
  always_ff @(posedge i_clk) begin
    o_ports <= i_level;
  end
endmodule
`default_nettype wire

// [testbench/motor_halt_and_home_offset_bench.sv]
// Self-checking bench for the motor halt and home-offset block
`timescale 1ns/100ps
`default_nettype none
module motor_halt_and_home_offset_bench;
  import halt_home_pkg::*;
  logic        clk = 1'b0;        // 50 MHz clock
  logic        rst_n = 1'b0;      // Reset, low active
  logic [7:0]  level = 8'h00;     // Requested port levels
  logic [7:0]  gen_in;            // Port levels from the model
  logic        start = 1'b0;      // Program start input
  logic        aclr = 1'b0;       // Alarm clear input
  logic        seek_done = 1'b0;  // Home sensor found
  logic        ofs_done = 1'b0;   // Offset move done
  logic        stopped = 1'b1;    // Motor at rest
  logic [7:0]  awaddr = 8'h00;    // Write address
  logic        awvalid = 1'b0;    // Write address valid
  logic [31:0] wdata = 32'h0;     // Write data
  logic        wvalid = 1'b0;     // Write data valid
  logic        bready = 1'b0;     // Response ready
  logic [7:0]  araddr = 8'h00;    // Read address
  logic        arvalid = 1'b0;    // Read address valid
  logic        rready = 1'b0;     // Read data ready
  logic        awready, wready, bvalid, arready, rvalid, prog_run;
  logic [1:0]  bresp, rresp;      // Responses
  logic [31:0] rdata;             // Read data
  stop_kind_t  stop;              // Stop request
  stop_kind_t  seen;              // Last stop request seen
  motion_req_t motion;            // Motion request
  int          fails = 0;         // Mismatch count
  int          tests_run = 0;     // Comparison count

  always #10 clk = ~clk;

  // Catch one-cycle stop requests
  always @(posedge clk) begin
    if (stop !== STOP_NONE) seen <= stop;
  end

  gen_in_model #(.PORTS(8)) gen_in_model_i (.i_clk(clk), .i_level(level), .o_ports(gen_in));

  motor_halt_and_home_offset #(.PORTS(8)) motor_halt_and_home_offset_i (
    .I_MCLK(clk), .I_RESET_N(rst_n), .I_GEN_IN(gen_in), .I_START(start),
    .I_ALARM_CLEAR(aclr), .I_SEEK_DONE(seek_done), .I_OFS_DONE(ofs_done),
    .I_STOPPED(stopped), .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready),
    .I_WDATA(wdata), .I_WSTRB(4'hf), .I_WVALID(wvalid), .O_WREADY(wready),
    .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr),
    .I_ARVALID(arvalid), .O_ARREADY(arready), .O_RDATA(rdata), .O_RRESP(rresp),
    .O_RVALID(rvalid), .I_RREADY(rready), .O_STOP(stop), .O_MOTION(motion),
    .O_PROG_RUN(prog_run));

  // Verdict and end of run
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Compare and count
  task check(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      $display("wrong value at %0t: %s", $time, m);
      fails++;
    end
  endtask

  // Write with both channels offered together
  task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      n++;
    end while (bvalid !== 1'b1 && n < 50);
    bready <= 1'b0;
    check({31'h0, bvalid}, 32'h1, "write answered");
    check({30'h0, bresp}, {30'h0, er}, "write response");
    // Let one edge pass so the next call never re-drives the same signals
    @(posedge clk);
  endtask

  // Read; data judged only on a normal response
  task axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      n++;
    end while (rvalid !== 1'b1 && n < 50);
    rready <= 1'b0;
    check({31'h0, rvalid}, 32'h1, "read answered");
    check({30'h0, rresp}, {30'h0, er}, "read response");
    if (er == RESP_OKAY) check(rdata, ed, "read data");
    // Let one edge pass so the next call never re-drives the same signals
    @(posedge clk);
  endtask

  // Stop kind caught over the next few cycles
  task expect_stop(input stop_kind_t e);
    repeat (6) @(posedge clk);
    check({30'h0, seen}, {30'h0, e}, "stop kind");
  endtask

  // One-cycle pulse: 0 seek done, 1 offset done, 2 start, else alarm clear
  task pulse(input int w);
    case (w)
      0: seek_done <= 1'b1;
      1: ofs_done <= 1'b1;
      2: start <= 1'b1;
      default: aclr <= 1'b1;
    endcase
    @(posedge clk);
    seek_done <= 1'b0;
    ofs_done <= 1'b0;
    start <= 1'b0;
    aclr <= 1'b0;
  endtask

  task t_defaults;
    axi_rd(CFG_OFS, 32'h1, RESP_OKAY);
    axi_rd(OFFSET_OFS, 32'h0, RESP_OKAY);
    axi_rd(STATUS_OFS, 32'h0, RESP_OKAY);
    axi_rd(CTRL_OFS, 32'h0, RESP_OKAY);
    check({31'h0, prog_run}, 32'h0, "run after reset");
  endtask

  task t_offset_range;
    logic [31:0] wv [3];
    logic [31:0] rv [3];
    wv = '{32'h00ffffff, 32'h007fffff, 32'h00800000};
    rv = '{32'hffffffff, 32'h007fffff, 32'hff800000};
    for (int i = 0; i < 3; i++) begin
      axi_wr(OFFSET_OFS, wv[i], RESP_OKAY);
      axi_rd(OFFSET_OFS, rv[i], RESP_OKAY);
    end
  endtask

  task t_seek;
    int n;
    axi_wr(OFFSET_OFS, 32'h00002710, RESP_OKAY);
    for (int d = 0; d < 2; d++) begin
      axi_wr(CTRL_OFS, 32'h1 << (d ? CTRL_HSP_BIT : CTRL_HSN_BIT), RESP_OKAY);
      for (n = 0; n < 8 && motion.seek_go !== 1'b1; n++) @(posedge clk);
      check({31'h0, motion.seek_dir}, d, "seek direction");
      axi_rd(STATUS_OFS, 32'h2 | (d << 3), RESP_OKAY);
      pulse(0);
      for (n = 0; n < 8 && motion.ofs_go !== 1'b1; n++) @(posedge clk);
      check({8'h0, motion.ofs_steps}, 32'h00002710, "offset applied");
      axi_wr(SPEED_OFS, 32'h0000c350 + d, RESP_OKAY);
      @(posedge clk);
      check({8'h0, motion.speed}, 32'h0000c350 + d, "new speed in offset");
      check({31'h0, motion.ofs_go}, 32'h1, "offset still moving");
      pulse(1);
      for (n = 0; n < 8 && motion.ofs_go !== 1'b0; n++) @(posedge clk);
      check({31'h0, motion.ofs_go}, 32'h0, "offset finished");
    end
  endtask

  task t_halt_cmd;
    for (int a = 0; a < 2; a++) begin
      axi_wr(CFG_OFS, a, RESP_OKAY);
      axi_wr(CTRL_OFS, 32'h1 << CTRL_HSP_BIT, RESP_OKAY);
      seen = STOP_NONE;
      axi_wr(CTRL_OFS, 32'h1 << CTRL_HALT_BIT, RESP_OKAY);
      expect_stop(a ? STOP_DECEL : STOP_IMMED);
      check({31'h0, motion.seek_go}, 32'h0, "seek not halted");
    end
  endtask

  task t_halt_input;
    axi_wr(CTRL_OFS, 32'h1 << CTRL_RUN_BIT, RESP_OKAY);
    axi_wr(CFG_OFS, 32'h31, RESP_OKAY);
    seen = STOP_NONE;
    level <= 8'h08;
    expect_stop(STOP_DECEL);
    check({31'h0, prog_run}, 32'h1, "program keeps running");
    level <= 8'h00;
    repeat (3) @(posedge clk);
    seen = STOP_NONE;
    expect_stop(STOP_NONE);
    axi_wr(CFG_OFS, 32'h33, RESP_OKAY);
    seen = STOP_NONE;
    expect_stop(STOP_DECEL);
  endtask

  task t_reinit;
    for (int k = 0; k < 4; k++) begin
      axi_wr(CFG_OFS, 32'h33, RESP_OKAY);
      axi_wr(OFFSET_OFS, 32'h5, RESP_OKAY);
      if (k == 0) axi_wr(CTRL_OFS, 32'h1 << CTRL_RUN_BIT, RESP_OKAY);
      if (k == 1) pulse(2);
      if (k == 2) pulse(3);
      if (k == 3) axi_wr(CTRL_OFS, 32'h1 << CTRL_ACLR_BIT, RESP_OKAY);
      repeat (3) @(posedge clk);
      seen = STOP_NONE;
      expect_stop(STOP_NONE);
      axi_rd(OFFSET_OFS, (k < 2) ? 32'h5 : 32'h0, RESP_OKAY);
      axi_rd(CFG_OFS, 32'h31, RESP_OKAY);
    end
  endtask

  task t_unmapped;
    axi_wr(8'h14, 32'h1, RESP_SLVERR);
    axi_rd(8'h14, 32'h0, RESP_SLVERR);
    axi_rd(CFG_OFS, 32'h31, RESP_OKAY);
  endtask

  // Watchdog against a hang
  initial begin
    #400000;
    fails++;
    report_and_stop;
  end

  // Main sequence
  initial begin
    seen = STOP_NONE;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_defaults;
    t_offset_range;
    t_seek;
    t_halt_cmd;
    t_halt_input;
    t_reinit;
    t_unmapped;
    report_and_stop;
  end
endmodule
`default_nettype wire
